/* rtl/fcd_flash_cmd_defs.vh */
// Constants of the flash command decoder: codes, offsets, resets, timing.
`ifndef FCD_FLASH_CMD_DEFS_VH
`define FCD_FLASH_CMD_DEFS_VH

// Unlock cycles.
`define FCD_UNLOCK1_DATA 8'haa
`define FCD_UNLOCK1_ADDR 12'h555
`define FCD_UNLOCK2_DATA 8'h55
`define FCD_UNLOCK2_ADDR 12'haaa

// Command and confirmation bytes.
`define FCD_CMD_PROGRAM 8'ha0
`define FCD_CMD_ERASE_SETUP 8'h80
`define FCD_CMD_SECTOR 8'h30
`define FCD_CMD_BULK 8'h10
`define FCD_CMD_PROTECT_QUERY 8'h90
`define FCD_CMD_SUSPEND 8'hb0
`define FCD_CMD_RESET 8'hf0

// Protection answer and the address pattern of the query read.
`define FCD_PROT_YES 8'h01
`define FCD_PROT_NO 8'h00
`define FCD_PQ_MASK 12'h043
`define FCD_PQ_MATCH 12'h002

// Sector groups inside the combined six-bit select vector.
`define FCD_PRIMARY_SECTORS 6'h0f
`define FCD_SECONDARY_SECTORS 6'h30

// Register offsets on the APB.
`define FCD_REG_TIMEOUT 12'h000
`define FCD_REG_STATUS 12'h004

// Reset value of the inter-byte time-out, in clock cycles.
`define FCD_TIMEOUT_RST 16'h0fa0

// Timing.
`define FCD_CLK_PERIOD_NS 8
`define FCD_ERASE_WIN_NS 80000
`define FCD_ERASE_WIN_CYC 16'h2710

`endif

/* rtl/fcd_flash_command_decoder.v */
// Flash command sequence decoder with status reads and an APB slave.
`timescale 1ns/100ps
`include "fcd_flash_cmd_defs.vh"

module fcd_flash_command_decoder #(
  parameter [15:0] ERASE_WIN_CYC = `FCD_ERASE_WIN_CYC
) (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Host parallel bus, asynchronous to clk.
  input wire [11:0] hostAddr,
  input wire [7:0] hostWrData,
  input wire writeStrobeLineN,
  input wire readStrobeN,
  input wire [3:0] primarySectorSelect,
  input wire [1:0] secondarySectorSelect,
  // Read data back to the host bus.
  output reg [7:0] hostRdData_ff,
  output reg hostRdOe_ff,
  output reg readyBusyPin_ff,
  // Array side, same clock.
  input wire [7:0] arrayRdData,
  input wire [5:0] sectorProtect,
  input wire algoDone,
  input wire algoFail,
  output reg programStart_ff,
  output reg eraseStart_ff,
  output reg bulkErase_ff,
  output reg targetSecondary_ff,
  output reg [11:0] programAddress_ff,
  output reg [7:0] programData_ff,
  output reg [5:0] eraseMask_ff,
  output reg suspendReq_ff,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff
);

  localparam [12:0] S_READ = 13'h0001;
  localparam [12:0] S_UNL1 = 13'h0002;
  localparam [12:0] S_UNL2 = 13'h0004;
  localparam [12:0] S_PROG = 13'h0008;
  localparam [12:0] S_ESET = 13'h0010;
  localparam [12:0] S_EUN1 = 13'h0020;
  localparam [12:0] S_EUN2 = 13'h0040;
  localparam [12:0] S_PQRY = 13'h0080;
  localparam [12:0] S_BUSYP = 13'h0100;
  localparam [12:0] S_EWIN = 13'h0200;
  localparam [12:0] S_BUSYE = 13'h0400;
  localparam [12:0] S_SUSP = 13'h0800;
  localparam [12:0] S_FAIL = 13'h1000;

  // Two-stage synchronisers plus one edge stage for the strobes.
  reg [11:0] addrS1_ff;
  reg [11:0] addrS2_ff;
  reg [7:0] dataS1_ff;
  reg [7:0] dataS2_ff;
  reg [5:0] selS1_ff;
  reg [5:0] selS2_ff;
  reg [2:0] wrSync_ff;
  reg [2:0] rdSync_ff;

  reg [12:0] state_ff;
  reg [15:0] cnt_ff;
  reg [15:0] timeout_ff;
  reg [11:0] cmdAddr_ff;
  reg [5:0] cmdSel_ff;
  reg suspFlag_ff;
  reg failFlag_ff;
  reg toggle_ff;

  wire wrFall = wrSync_ff[2] & ~wrSync_ff[1];
  wire wrRise = ~wrSync_ff[2] & wrSync_ff[1];
  wire rdFall = rdSync_ff[2] & ~rdSync_ff[1];
  wire wrEv = wrRise & (|cmdSel_ff);
  wire [7:0] wrByte = dataS2_ff;
  wire isEven = ~cmdAddr_ff[0];
  wire atUnl1 = cmdAddr_ff == `FCD_UNLOCK1_ADDR;
  wire isUnl1 = wrByte == `FCD_UNLOCK1_DATA && atUnl1;
  wire isUnl2 = wrByte == `FCD_UNLOCK2_DATA &&
    cmdAddr_ff == `FCD_UNLOCK2_ADDR;
  wire isReset = wrByte == `FCD_CMD_RESET && isEven;
  wire isSuspend = wrByte == `FCD_CMD_SUSPEND && isEven;
  wire isResume = wrByte == `FCD_CMD_SECTOR && isEven;
  wire cmdSecondary = |(cmdSel_ff & `FCD_SECONDARY_SECTORS);
  wire cmdProtected = |(cmdSel_ff & sectorProtect);
  wire [12:0] retState = suspFlag_ff ? S_SUSP : S_READ;
  wire inSequence = |(state_ff & (S_UNL1 | S_UNL2 | S_PROG | S_ESET |
    S_EUN1 | S_EUN2));
  wire seqTimeout = inSequence && cnt_ff >= timeout_ff;
  wire algoBusy = |(state_ff & (S_BUSYP | S_EWIN | S_BUSYE));
  wire pollBit = (state_ff == S_BUSYP) & ~programData_ff[7];
  wire ewinBit = state_ff == S_BUSYE;
  wire [7:0] statusByte = {pollBit, toggle_ff, failFlag_ff, 1'b0,
    ewinBit, 3'b000};
  wire [5:0] bulkMask = cmdSecondary ? `FCD_SECONDARY_SECTORS :
    `FCD_PRIMARY_SECTORS;
  wire failClear = wrEv && isReset && state_ff == S_FAIL;
  wire apbAccess = psel & penable & pready_ff;
  wire apbHitTimeout = paddr == `FCD_REG_TIMEOUT;
  wire apbHitStatus = paddr == `FCD_REG_STATUS;

  // Host pins cross into clk through two flops before anything reads them.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addrS1_ff <= 12'h000;
      addrS2_ff <= 12'h000;
      dataS1_ff <= 8'h00;
      dataS2_ff <= 8'h00;
      selS1_ff <= 6'h00;
      selS2_ff <= 6'h00;
      wrSync_ff <= 3'h7;
      rdSync_ff <= 3'h7;
    end else begin
      addrS1_ff <= hostAddr;
      addrS2_ff <= addrS1_ff;
      dataS1_ff <= hostWrData;
      dataS2_ff <= dataS1_ff;
      selS1_ff <= {secondarySectorSelect, primarySectorSelect};
      selS2_ff <= selS1_ff;
      wrSync_ff <= {wrSync_ff[1:0], writeStrobeLineN};
      rdSync_ff <= {rdSync_ff[1:0], readStrobeN};
    end
  end

  // Address and selects are caught at the falling strobe edge.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdAddr_ff <= 12'h000;
      cmdSel_ff <= 6'h00;
    end else if (wrFall) begin
      cmdAddr_ff <= addrS2_ff;
      cmdSel_ff <= selS2_ff;
    end
  end

  // Failure flag: a new failure wins over the reset command's clear.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      failFlag_ff <= 1'b0;
    end else begin
      failFlag_ff <= algoFail | (failFlag_ff & ~failClear);
    end
  end

  // Command sequencer.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= S_READ;
      cnt_ff <= 16'h0000;
      suspFlag_ff <= 1'b0;
      programStart_ff <= 1'b0;
      eraseStart_ff <= 1'b0;
      bulkErase_ff <= 1'b0;
      targetSecondary_ff <= 1'b0;
      programAddress_ff <= 12'h000;
      programData_ff <= 8'h00;
      eraseMask_ff <= 6'h00;
      suspendReq_ff <= 1'b0;
    end else begin
      programStart_ff <= 1'b0;
      eraseStart_ff <= 1'b0;
      if (wrEv) begin
        cnt_ff <= 16'h0000;
      end else if (cnt_ff != 16'hffff) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
      if (seqTimeout) begin
        state_ff <= retState;
      end else begin
        case (state_ff)
          S_READ: begin
            if (wrEv && isUnl1) begin
              state_ff <= S_UNL1;
              targetSecondary_ff <= cmdSecondary;
            end
          end
          S_SUSP: begin
            if (wrEv && isResume) begin
              state_ff <= S_BUSYE;
              suspendReq_ff <= 1'b0;
              suspFlag_ff <= 1'b0;
            end else if (wrEv && isUnl1) begin
              state_ff <= S_UNL1;
              targetSecondary_ff <= cmdSecondary;
            end
          end
          S_UNL1: begin
            if (wrEv) begin
              state_ff <= isUnl2 ? S_UNL2 : retState;
            end
          end
          S_UNL2: begin
            if (wrEv) begin
              if (atUnl1 && wrByte == `FCD_CMD_PROGRAM) begin
                state_ff <= S_PROG;
              end else if (atUnl1 && wrByte == `FCD_CMD_PROTECT_QUERY) begin
                state_ff <= S_PQRY;
              end else if (atUnl1 && wrByte == `FCD_CMD_ERASE_SETUP &&
                  !suspFlag_ff) begin
                state_ff <= S_ESET;
              end else begin
                state_ff <= retState;
              end
            end
          end
          S_PROG: begin
            if (wrEv) begin
              // Protected sectors and the sectors under a suspended erase
              // are refused; the erased data must not be disturbed.
              if (cmdProtected ||
                  (suspFlag_ff && |(cmdSel_ff & eraseMask_ff))) begin
                state_ff <= retState;
              end else begin
                state_ff <= S_BUSYP;
                programStart_ff <= 1'b1;
                programAddress_ff <= cmdAddr_ff;
                programData_ff <= wrByte;
                targetSecondary_ff <= cmdSecondary;
              end
            end
          end
          S_ESET: begin
            if (wrEv) begin
              state_ff <= isUnl1 ? S_EUN1 : S_READ;
            end
          end
          S_EUN1: begin
            if (wrEv) begin
              state_ff <= isUnl2 ? S_EUN2 : S_READ;
            end
          end
          S_EUN2: begin
            if (wrEv) begin
              if (wrByte == `FCD_CMD_SECTOR) begin
                state_ff <= S_EWIN;
                bulkErase_ff <= 1'b0;
                eraseMask_ff <= cmdSel_ff & ~sectorProtect;
                targetSecondary_ff <= cmdSecondary;
              end else if (wrByte == `FCD_CMD_BULK && atUnl1) begin
                // A fully protected sector group starts no erase, though bulkErase_ff, eraseMask_ff and targetSecondary_ff still update.
                if (|(bulkMask & ~sectorProtect)) begin
                  state_ff <= S_BUSYE;
                  eraseStart_ff <= 1'b1;
                end else begin
                  state_ff <= S_READ;
                end
                bulkErase_ff <= 1'b1;
                eraseMask_ff <= bulkMask & ~sectorProtect;
                targetSecondary_ff <= cmdSecondary;
              end else begin
                state_ff <= S_READ;
              end
            end
          end
          S_EWIN: begin
            if (wrEv && wrByte == `FCD_CMD_SECTOR) begin
              eraseMask_ff <= eraseMask_ff | (cmdSel_ff & ~sectorProtect);
            end else if (cnt_ff >= ERASE_WIN_CYC) begin
              if (|eraseMask_ff) begin
                state_ff <= S_BUSYE;
                eraseStart_ff <= 1'b1;
              end else begin
                state_ff <= S_READ;
              end
            end
          end
          S_BUSYE: begin
            if (algoFail) begin
              state_ff <= S_FAIL;
            end else if (algoDone) begin
              state_ff <= S_READ;
            end else if (wrEv && isSuspend && !bulkErase_ff) begin
              state_ff <= S_SUSP;
              suspendReq_ff <= 1'b1;
              suspFlag_ff <= 1'b1;
            end
          end
          S_BUSYP: begin
            if (algoFail) begin
              state_ff <= S_FAIL;
            end else if (algoDone) begin
              state_ff <= retState;
            end
          end
          S_PQRY: begin
            if (wrEv && isReset) begin
              state_ff <= retState;
            end
          end
          S_FAIL: begin
            if (wrEv && isReset) begin
              state_ff <= S_READ;
              suspFlag_ff <= 1'b0;
              suspendReq_ff <= 1'b0;
            end
          end
          default: begin
            state_ff <= S_READ;
          end
        endcase
      end
    end
  end

  // Host read path. Array data is assumed to follow the bus address.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hostRdData_ff <= 8'h00;
      hostRdOe_ff <= 1'b0;
      toggle_ff <= 1'b0;
      readyBusyPin_ff <= 1'b1;
    end else begin
      hostRdOe_ff <= ~rdSync_ff[1];
      readyBusyPin_ff <= ~algoBusy;
      if (rdFall) begin
        if (algoBusy && |selS2_ff) begin
          hostRdData_ff <= statusByte;
          toggle_ff <= ~toggle_ff;
        end else if (state_ff == S_PQRY &&
            (addrS2_ff & `FCD_PQ_MASK) == `FCD_PQ_MATCH) begin
          hostRdData_ff <= |(selS2_ff & sectorProtect) ?
            `FCD_PROT_YES : `FCD_PROT_NO;
        end else if (state_ff == S_FAIL) begin
          hostRdData_ff <= statusByte;
        end else begin
          hostRdData_ff <= arrayRdData;
        end
      end
    end
  end

  // APB slave: one wait state; unmapped offsets answer with an error.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      timeout_ff <= `FCD_TIMEOUT_RST;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      if (psel && penable && !pready_ff) begin
        pslverr_ff <= ~(apbHitTimeout | apbHitStatus) |
          (pwrite & apbHitStatus);
        if (apbHitTimeout) begin
          prdata_ff <= {16'h0000, timeout_ff};
        end else if (apbHitStatus) begin
          prdata_ff <= {16'h0000, failFlag_ff, suspFlag_ff,
            readyBusyPin_ff, state_ff};
        end else begin
          prdata_ff <= 32'h00000000;
        end
      end
      if (apbAccess && pwrite && apbHitTimeout) begin
        timeout_ff <= pwdata[15:0];
      end
    end
  end

endmodule // fcd_flash_command_decoder

/* verif/fcd_flash_cmd_chk.sv */
// Concurrent checks on the ports of the flash command decoder.
`timescale 1ns/100ps
`include "fcd_flash_cmd_defs.vh"
module fcd_flash_cmd_chk (
  // Clock, reset and APB.
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata_ff,
  input wire pready_ff,
  input wire pslverr_ff,
  // Host bus and array side.
  input wire readStrobeN,
  input wire hostRdOe_ff,
  input wire readyBusyPin_ff,
  input wire algoDone,
  input wire algoFail,
  input wire [5:0] sectorProtect,
  input wire programStart_ff,
  input wire eraseStart_ff,
  input wire bulkErase_ff,
  input wire [5:0] eraseMask_ff,
  input wire suspendReq_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // First access edge of a transfer that is not answered yet.
  sequence apbAccess;
    psel && penable && !pready_ff;
  endsequence
  // The strobe has stayed put long enough to cross the synchroniser.
  sequence rdSettled;
    $stable(readStrobeN) [*4];
  endsequence
  apb_wait_a: assert property (apbAccess |=> pready_ff)
    else $error("APB answer not after one wait state");
  apb_once_a: assert property (pready_ff |=> !pready_ff)
    else $error("APB ready held longer than one cycle");
  apb_err_a: assert property (apbAccess ##0 (paddr != `FCD_REG_TIMEOUT &&
    paddr != `FCD_REG_STATUS) |=> pslverr_ff && prdata_ff == 32'h0)
    else $error("Unmapped APB offset not refused");
  rd_oe_a: assert property (rdSettled |-> hostRdOe_ff == !readStrobeN)
    else $error("Read enable does not follow the read strobe");
  busy_prog_a: assert property (programStart_ff |=> !readyBusyPin_ff [*2])
    else $error("Busy not shown after a program start");
  ready_done_a: assert property (algoDone && !algoFail && !suspendReq_ff
    |-> ##[1:3] readyBusyPin_ff)
    else $error("Ready not restored after the cycle ended");
  susp_erase_a: assert property ($rose(suspendReq_ff)
    |-> !bulkErase_ff && !$past(readyBusyPin_ff))
    else $error("Suspend entered outside a running sector erase");
  mask_prot_a: assert property (eraseStart_ff && !bulkErase_ff
    |-> (eraseMask_ff & sectorProtect) == 6'h00)
    else $error("Protected sector left in the erase mask");
  prog_pulse_a: assert property (programStart_ff |=> !programStart_ff)
    else $error("Program start pulse longer than one cycle");
endmodule // fcd_flash_cmd_chk

bind fcd_flash_command_decoder fcd_flash_cmd_chk u_fcd_flash_cmd_chk (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .readStrobeN(readStrobeN),
  .hostRdOe_ff(hostRdOe_ff), .readyBusyPin_ff(readyBusyPin_ff),
  .algoDone(algoDone), .algoFail(algoFail), .sectorProtect(sectorProtect),
  .programStart_ff(programStart_ff), .eraseStart_ff(eraseStart_ff),
  .bulkErase_ff(bulkErase_ff), .eraseMask_ff(eraseMask_ff),
  .suspendReq_ff(suspendReq_ff));

/* verif/fcd_host_model.sv */
// Host microcontroller model that drives the parallel flash bus.
`timescale 1ns/100ps
module fcd_host_model (
  // Clock and read answer.
  input wire clk,
  input wire [7:0] hostRdData_ff,
  // Parallel bus.
  output reg [11:0] hostAddr,
  output reg [7:0] hostWrData,
  output reg writeStrobeLineN,
  output reg readStrobeN,
  output wire [3:0] primarySectorSelect,
  output wire [1:0] secondarySectorSelect
);
  reg [5:0] selV;
  assign {secondarySectorSelect, primarySectorSelect} = selV;
  initial begin
    selV = 6'h00;
    writeStrobeLineN = 1'b1;
    readStrobeN = 1'b1;
    hostAddr = 12'h000;
    hostWrData = 8'h00;
  end
  task automatic hold(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Six cycles a phase so the synchroniser sees it; released address and data lines are
  // inverted and the selects cleared, because a stale value would hide a late capture.
  task automatic wr(input [11:0] a, input [7:0] d, input [5:0] s);
    begin
      @(posedge clk);
      hostAddr <= a;
      hostWrData <= d;
      // The model fetches no code over this bus, so it never commands
      // an array that it is running from.
      selV <= s;
      hold(1);
      writeStrobeLineN <= 1'b0;
      hold(6);
      writeStrobeLineN <= 1'b1;
      hold(6);
      selV <= 6'h00;
      hostAddr <= ~a;
      hostWrData <= ~d;
      hold(1);
    end
  endtask
  task automatic rd(input [11:0] a, input [5:0] s, output [7:0] d);
    begin
      @(posedge clk);
      hostAddr <= a;
      selV <= s;
      hold(1);
      readStrobeN <= 1'b0;
      hold(5);
      d = hostRdData_ff;
      readStrobeN <= 1'b1;
      hold(5);
      selV <= 6'h00;
      hostAddr <= ~a;
      hold(1);
    end
  endtask
endmodule // fcd_host_model

/* verif/fcd_flash_command_decoder_tb_top.sv */
// Self-checking testbench of the flash command decoder.
`timescale 1ns/100ps
`include "fcd_flash_cmd_defs.vh"
module fcd_flash_command_decoder_tb_top;
  reg clk, sys_rst, algoDone, algoFail, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  reg [7:0] arrayRdData, d1, d2;
  reg [5:0] sectorProtect;
  wire [11:0] hostAddr, programAddress_ff;
  wire [7:0] hostWrData, hostRdData_ff, programData_ff;
  wire [3:0] pSel;
  wire [1:0] sSel;
  wire [5:0] eraseMask_ff;
  wire [31:0] prdata_ff;
  wire wrN, rdN, hostRdOe_ff, readyBusyPin_ff, programStart_ff, eraseStart_ff;
  wire bulkErase_ff, targetSecondary_ff, suspendReq_ff, pready_ff, pslverr_ff;
  integer n_fail, checks, cyc, nProg, nErase;
  fcd_flash_command_decoder #(.ERASE_WIN_CYC(16'd40))
  u_fcd_flash_command_decoder (.clk(clk), .sys_rst(sys_rst),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .writeStrobeLineN(wrN),
    .readStrobeN(rdN), .primarySectorSelect(pSel),
    .secondarySectorSelect(sSel), .hostRdData_ff(hostRdData_ff),
    .hostRdOe_ff(hostRdOe_ff), .readyBusyPin_ff(readyBusyPin_ff),
    .arrayRdData(arrayRdData), .sectorProtect(sectorProtect),
    .algoDone(algoDone), .algoFail(algoFail),
    .programStart_ff(programStart_ff), .eraseStart_ff(eraseStart_ff),
    .bulkErase_ff(bulkErase_ff), .targetSecondary_ff(targetSecondary_ff),
    .programAddress_ff(programAddress_ff), .programData_ff(programData_ff),
    .eraseMask_ff(eraseMask_ff), .suspendReq_ff(suspendReq_ff),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff));
  fcd_host_model u_fcd_host_model (.clk(clk), .hostRdData_ff(hostRdData_ff),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .writeStrobeLineN(wrN),
    .readStrobeN(rdN), .primarySectorSelect(pSel),
    .secondarySectorSelect(sSel));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (programStart_ff === 1'b1) nProg <= nProg + 1;
    if (eraseStart_ff === 1'b1) nErase <= nErase + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    begin
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic apb(input w, input [11:0] a, input [31:0] dw,
    input [31:0] x, input xe);
    reg [31:0] r;
    reg e;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dw;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // The request stands until ready is seen at a rising edge.
      while (pready_ff !== 1'b1) @(posedge clk);
      r = prdata_ff;
      e = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
      if (!w) chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
    end
  endtask
  task automatic hw(input [11:0] a, input [7:0] dv, input [5:0] s);
    u_fcd_host_model.wr(a, dv, s);
  endtask
  task automatic cmd(input [7:0] c, input [5:0] s);
    begin
      hw(`FCD_UNLOCK1_ADDR, `FCD_UNLOCK1_DATA, s);
      hw(`FCD_UNLOCK2_ADDR, `FCD_UNLOCK2_DATA, s);
      hw(`FCD_UNLOCK1_ADDR, c, s);
    end
  endtask
  task automatic hr(input [11:0] a, input [5:0] s, input [7:0] m,
    input [7:0] x);
    begin
      u_fcd_host_model.rd(a, s, d1);
      chk(d1 & m, x);
    end
  endtask
  task automatic st(input integer n);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
    end
  endtask
  // The engine reports the end of a cycle with a one-cycle pulse.
  task automatic fin(input f);
    begin
      @(posedge clk);
      algoDone <= !f;
      algoFail <= f;
      @(posedge clk);
      algoDone <= 1'b0;
      algoFail <= 1'b0;
      st(3);
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    {algoDone, algoFail, psel, penable, pwrite} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    arrayRdData = 8'h5a;
    sectorProtect = 6'h04;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    nProg = 0;
    nErase = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    st(2);
    chk(readyBusyPin_ff, 1'b1);
    apb(1'b0, `FCD_REG_TIMEOUT, 32'h0, 32'h0fa0, 1'b0);
    apb(1'b0, `FCD_REG_STATUS, 32'h0, 32'h2001, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
    apb(1'b1, `FCD_REG_STATUS, 32'h1, 32'h0, 1'b1);
    hr(12'h123, 6'h01, 8'hff, 8'h5a);
    hw(12'h000, `FCD_CMD_SUSPEND, 6'h01);
    st(6);
    chk(suspendReq_ff, 1'b0);
    cmd(`FCD_CMD_PROGRAM, 6'h10);
    hw(12'h234, 8'h3c, 6'h10);
    st(6);
    chk(nProg, 1);
    chk({targetSecondary_ff, programAddress_ff}, 13'h1234);
    chk(programData_ff, 8'h3c);
    chk(readyBusyPin_ff, 1'b0);
    hr(12'h234, 6'h10, 8'ha0, 8'h80);
    d2 = d1;
    hr(12'h234, 6'h10, 8'ha0, 8'h80);
    chk(d1[6] ^ d2[6], 1'b1);
    fin(1'b0);
    chk(readyBusyPin_ff, 1'b1);
    cmd(8'h00, 6'h01);
    apb(1'b0, `FCD_REG_STATUS, 32'h0, 32'h2001, 1'b0);
    apb(1'b1, `FCD_REG_TIMEOUT, 32'h40, 32'h0, 1'b0);
    apb(1'b0, `FCD_REG_TIMEOUT, 32'h0, 32'h40, 1'b0);
    hw(`FCD_UNLOCK1_ADDR, `FCD_UNLOCK1_DATA, 6'h01);
    st(100);
    hw(`FCD_UNLOCK2_ADDR, `FCD_UNLOCK2_DATA, 6'h01);
    hw(`FCD_UNLOCK1_ADDR, `FCD_CMD_PROGRAM, 6'h01);
    hw(12'h100, 8'h00, 6'h01);
    st(6);
    chk(nProg, 1);
    apb(1'b1, `FCD_REG_TIMEOUT, 32'h0fa0, 32'h0, 1'b0);
    cmd(`FCD_CMD_PROGRAM, 6'h00);
    hw(12'h100, 8'h00, 6'h00);
    st(6);
    chk(nProg, 1);
    cmd(`FCD_CMD_PROTECT_QUERY, 6'h04);
    hr(12'h002, 6'h04, 8'hff, `FCD_PROT_YES);
    hr(12'h002, 6'h01, 8'hff, `FCD_PROT_NO);
    hw(12'h000, `FCD_CMD_RESET, 6'h01);
    hr(12'h100, 6'h01, 8'hff, 8'h5a);
    cmd(`FCD_CMD_ERASE_SETUP, 6'h01);
    cmd(`FCD_CMD_SECTOR, 6'h01);
    hw(12'h000, `FCD_CMD_SECTOR, 6'h02);
    hw(12'h000, `FCD_CMD_SECTOR, 6'h04);
    st(60);
    chk({nErase[1:0], eraseMask_ff}, 8'h43);
    hw(12'h000, `FCD_CMD_SUSPEND, 6'h01);
    st(6);
    chk(suspendReq_ff, 1'b1);
    hr(12'h100, 6'h08, 8'hff, 8'h5a);
    hw(12'h000, `FCD_CMD_SECTOR, 6'h01);
    st(6);
    chk(suspendReq_ff, 1'b0);
    fin(1'b0);
    cmd(`FCD_CMD_ERASE_SETUP, 6'h02);
    cmd(`FCD_CMD_BULK, 6'h02);
    st(6);
    chk({nErase[1:0], bulkErase_ff}, 3'h5);
    hw(12'h000, `FCD_CMD_SUSPEND, 6'h02);
    st(6);
    chk(suspendReq_ff, 1'b0);
    fin(1'b0);
    cmd(`FCD_CMD_PROGRAM, 6'h01);
    hw(12'h100, 8'h00, 6'h01);
    st(6);
    fin(1'b1);
    hr(12'h100, 6'h01, 8'h20, 8'h20);
    hw(12'h000, `FCD_CMD_RESET, 6'h01);
    hr(12'h100, 6'h01, 8'hff, 8'h5a);
    tally_and_finish;
  end
endmodule // fcd_flash_command_decoder_tb_top
